// [pwc_pkg.sv]
// Purpose: Shared constants, types and helpers of the pulse width capture block.
// Assumes: One clock domain; synchronous active-high reset.
// Notes:   Register indices address the block's own register port, one 32-bit word each.
`default_nettype none
package pwc_pkg;

  // Rates.
  localparam longint unsigned CORE_RATE_HZ  = 80_000_000;
  localparam longint unsigned CLK_SYS_HZ    = 25_000_000;

  // Feature and field layout.
  localparam logic [31:0]     FEATURE_PULSE_WIDTH = 32'h0000_0005;
  localparam int              NUM_SRC             = 3;
  localparam int              SRC_SEL_LSB         = 0;
  localparam int              SRC_SEL_W           = 3;
  localparam int              MODE_CONT_BIT       = 1;
  localparam int              ENABLE_BIT          = 0;
  localparam int              STREAM_W            = 16;

  // Divider settings that are honoured; anything else runs at divide-by-one.
  localparam int              NUM_DIV             = 8;
  localparam logic [31:0]     DIV_ALLOWED [NUM_DIV] = '{32'h1, 32'h2, 32'h4, 32'h8,
                                                       32'h10, 32'h20, 32'h40, 32'h100};
  localparam logic [8:0]      DIV_ONE             = 9'h001;

  // Seconds are unsigned Q16.16, scaled through a fixed reciprocal of the core rate.
  localparam int              SEC_FRAC_BITS       = 16;
  localparam int              SEC_SHIFT           = 32;
  localparam logic [63:0]     SEC_SCALE = 64'((64'h1 << (SEC_FRAC_BITS + SEC_SHIFT)) / CORE_RATE_HZ);

  // Register indices.
  typedef logic [4:0] pwc_addr_t;
  localparam pwc_addr_t       ADDR_FEATURE_ENABLE  = 5'h00;
  localparam pwc_addr_t       ADDR_FEATURE_SELECT  = 5'h01;
  localparam pwc_addr_t       ADDR_TICK_SOURCE_SEL = 5'h02;
  localparam pwc_addr_t       ADDR_MODE_CONFIG     = 5'h03;
  localparam pwc_addr_t       ADDR_HIGH_TICKS      = 5'h04;
  localparam pwc_addr_t       ADDR_LOW_TICKS       = 5'h05;
  localparam pwc_addr_t       ADDR_HIGH_SECS       = 5'h06;
  localparam pwc_addr_t       ADDR_LOW_SECS        = 5'h07;
  localparam pwc_addr_t       ADDR_HIGH_TICKS_RC   = 5'h08;
  localparam pwc_addr_t       ADDR_HIGH_SECS_RC    = 5'h09;
  localparam pwc_addr_t       ADDR_STREAM_CAPTURE  = 5'h0A;
  localparam logic [2:0]      GRP_SRC_EN           = 3'h4;
  localparam logic [2:0]      GRP_DIV              = 3'h5;
  localparam logic [2:0]      GRP_WRAP             = 3'h6;

  typedef enum logic [2:0] {
    PWC_OFF  = 3'b000,
    PWC_ARM  = 3'b001,
    PWC_HIGH = 3'b010,
    PWC_LOW  = 3'b011,
    PWC_HOLD = 3'b100
  } pwc_state_e;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        stream;
    pwc_addr_t   addr;
    logic [31:0] wdata;
  } pwc_req_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } pwc_rsp_s;

  typedef struct packed {
    logic [8:0] cnt;
    logic       tick;
  } pwc_tick_s;

  typedef struct packed {
    pwc_state_e                 state;
    logic                       line_prev;
    logic [31:0]                feat_en;
    logic [31:0]                feat_sel;
    logic [31:0]                src_opts;
    logic [31:0]                mode_cfg;
    logic [NUM_SRC-1:0]         src_en;
    logic [NUM_SRC-1:0][31:0]   div;
    logic [NUM_SRC-1:0][31:0]   wrap;
    logic [31:0]                hi_cnt;
    logic [31:0]                lo_cnt;
    logic [31:0]                hi_meas;
    logic [31:0]                high_res;
    logic [31:0]                low_pend;
    logic [31:0]                low_cap;
    logic [STREAM_W-1:0]        stream_hi;
    pwc_rsp_s                   rsp;
  } pwc_core_s;

  function automatic logic [8:0] pwc_div_decode(input logic [31:0] setting);
    logic [8:0] d;
    d = DIV_ONE;
    for (int i = 0; i < NUM_DIV; i++)
    begin
      if (setting == DIV_ALLOWED[i])
        d = setting[8:0];
    end
    return d;
  endfunction

  function automatic logic [31:0] pwc_wrap_inc(input logic [31:0] cnt, input logic [31:0] wrap);
    logic [31:0] nxt;
    nxt = cnt + 32'h1;
    if (wrap != 32'h0 && nxt == wrap)
      nxt = 32'h0;
    return nxt;
  endfunction

endpackage
`default_nettype wire

// [pwc_tick_gen.sv]
// Purpose: One tick source: a prescaler giving a one-cycle tick every divider cycles.
// Assumes: Divider already decoded to 1..256.
// Notes:   The prescaler restarts whenever the source is switched off.
`default_nettype none
module pwc_tick_gen
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Configuration
  input  wire logic       src_enable,
  input  wire logic [8:0] divider,
  // Tick out
  output logic            tick
);
  import pwc_pkg::*;

  pwc_tick_s s_r;
  pwc_tick_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!src_enable)
    begin
      s_nxt.cnt = 9'h000;
    end
    else if (s_r.cnt >= 9'(divider - DIV_ONE))
    begin
      s_nxt.cnt  = 9'h000;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.cnt = 9'(s_r.cnt + 9'h001);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tick;

  tick_space_a: assert property (@(posedge clk_sys) disable iff (reset)
    (s_r.tick && divider > DIV_ONE && $stable(divider) && src_enable) |=> !s_r.tick)
    else $error("Tick repeated faster than the divider allows.");

endmodule
`default_nettype wire

// [pwc_seconds.sv]
// Purpose: Converts a tick count to seconds in unsigned Q16.16.
// Assumes: Tick rate is the core rate over the decoded divider.
// Notes:   A fixed reciprocal replaces a divider; the last fractional bit may be off by one.
`default_nettype none
module pwc_seconds
(
  // Count in
  input  wire logic [31:0] ticks,
  input  wire logic [8:0]  divider,
  // Seconds out
  output logic      [31:0] seconds
);
  import pwc_pkg::*;

  logic [63:0] prod;

  always_comb
  begin
    prod    = 64'(ticks) * 64'(divider) * SEC_SCALE;
    seconds = prod[SEC_SHIFT +: 32];
  end

endmodule
`default_nettype wire

// [pwc_top.sv]
// Purpose: Pulse width capture: high and low time of one input line in ticks and seconds.
// Assumes: line_in is synchronous to clk_sys; one register access per request cycle.
// Notes:   Results and answers are registered; seconds may sit one fractional step low.
`default_nettype none
module pwc_top
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // Measured line
  input  wire logic              line_in,
  // Register port
  input  wire pwc_pkg::pwc_req_s reg_req,
  output pwc_pkg::pwc_rsp_s      reg_rsp,
  // Status
  output logic                   meas_active
);
  import pwc_pkg::*;

  pwc_core_s              s_r;
  pwc_core_s              s_nxt;
  logic [NUM_SRC-1:0]     src_tick;
  logic [NUM_SRC-1:0][8:0] src_div;
  logic [SRC_SEL_W-1:0]   sel;
  logic                   sel_ok;
  logic                   tick;
  logic [31:0]            wrap;
  logic [8:0]             div_sel;
  logic [31:0]            hi_secs;
  logic [31:0]            lo_secs;
  logic                   active;
  logic                   cont;
  logic                   rise;
  logic                   fall;
  logic                   prim_rd;
  logic                   clr_rd;
  logic                   store;

  // Tick sources run whether or not this line is enabled, so several lines may share one.
  for (genvar g = 0; g < NUM_SRC; g++)
  begin : g_src
    assign src_div[g] = pwc_div_decode(s_r.div[g]);
    pwc_tick_gen u_tick
    (
      .clk_sys    (clk_sys),
      .reset      (reset),
      .src_enable (s_r.src_en[g]),
      .divider    (src_div[g]),
      .tick       (src_tick[g])
    );
  end

  assign sel     = s_r.src_opts[SRC_SEL_LSB +: SRC_SEL_W];
  assign sel_ok  = (sel < SRC_SEL_W'(NUM_SRC));
  assign tick    = sel_ok ? src_tick[sel[1:0]] : 1'b0;
  assign wrap    = sel_ok ? s_r.wrap[sel[1:0]] : 32'h0;
  assign div_sel = sel_ok ? src_div[sel[1:0]] : DIV_ONE;

  pwc_seconds u_sec_hi
  (
    .ticks   (s_r.high_res),
    .divider (div_sel),
    .seconds (hi_secs)
  );

  pwc_seconds u_sec_lo
  (
    .ticks   (s_r.low_cap),
    .divider (div_sel),
    .seconds (lo_secs)
  );

  assign active  = s_r.feat_en[ENABLE_BIT] && (s_r.feat_sel == FEATURE_PULSE_WIDTH);
  assign cont    = s_r.mode_cfg[MODE_CONT_BIT];
  assign rise    = line_in && !s_r.line_prev;
  assign fall    = !line_in && s_r.line_prev;
  assign clr_rd  = reg_req.rd && (reg_req.addr == ADDR_HIGH_TICKS_RC ||
                                  reg_req.addr == ADDR_HIGH_SECS_RC);
  assign prim_rd = clr_rd || (reg_req.rd && (reg_req.addr == ADDR_HIGH_TICKS ||
                                             reg_req.addr == ADDR_HIGH_SECS));
  assign store   = active && (s_r.state == PWC_LOW) && rise;

  always_comb
  begin
    logic [31:0] rd_val;
    logic        int_reg;
    rd_val    = 32'h0;
    int_reg   = 1'b0;
    s_nxt     = s_r;
    s_nxt.line_prev = line_in;
    s_nxt.rsp.valid = 1'b0;

    // Read side; unmapped indices read as zero.
    case (reg_req.addr)
      ADDR_FEATURE_ENABLE:  rd_val = s_r.feat_en;
      ADDR_FEATURE_SELECT:  rd_val = s_r.feat_sel;
      ADDR_TICK_SOURCE_SEL: rd_val = s_r.src_opts;
      ADDR_MODE_CONFIG:     rd_val = s_r.mode_cfg;
      ADDR_HIGH_TICKS, ADDR_HIGH_TICKS_RC:
      begin
        rd_val  = s_r.high_res;
        int_reg = 1'b1;
      end
      ADDR_LOW_TICKS:
      begin
        rd_val  = s_r.low_cap;
        int_reg = 1'b1;
      end
      ADDR_HIGH_SECS, ADDR_HIGH_SECS_RC: rd_val = hi_secs;
      ADDR_LOW_SECS:        rd_val = lo_secs;
      ADDR_STREAM_CAPTURE:  rd_val = {{(32 - STREAM_W){1'b0}}, s_r.stream_hi};
      default:
      begin
        if (reg_req.addr[1:0] < 2'(NUM_SRC))
        begin
          case (reg_req.addr[4:2])
            GRP_SRC_EN: rd_val = {31'h0, s_r.src_en[reg_req.addr[1:0]]};
            GRP_DIV:    rd_val = s_r.div[reg_req.addr[1:0]];
            GRP_WRAP:   rd_val = s_r.wrap[reg_req.addr[1:0]];
            default:    rd_val = 32'h0;
          endcase
        end
      end
    endcase

    if (reg_req.rd)
    begin
      s_nxt.rsp.valid = 1'b1;
      if (reg_req.stream && int_reg)
      begin
        s_nxt.rsp.data  = {{(32 - STREAM_W){1'b0}}, rd_val[STREAM_W-1:0]};
        s_nxt.stream_hi = rd_val[31:STREAM_W];
      end
      else
      begin
        s_nxt.rsp.data = rd_val;
      end
    end

    if (prim_rd)
      s_nxt.low_cap = s_r.low_pend;
    if (clr_rd)
    begin
      s_nxt.high_res = 32'h0;
      s_nxt.low_pend = 32'h0;
    end

    // Write side; results take no writes.
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        ADDR_FEATURE_ENABLE:  s_nxt.feat_en  = reg_req.wdata;
        ADDR_FEATURE_SELECT:  s_nxt.feat_sel = reg_req.wdata;
        ADDR_TICK_SOURCE_SEL: s_nxt.src_opts = reg_req.wdata;
        ADDR_MODE_CONFIG:     s_nxt.mode_cfg = reg_req.wdata;
        default:
        begin
          if (reg_req.addr[1:0] < 2'(NUM_SRC))
          begin
            case (reg_req.addr[4:2])
              GRP_SRC_EN: s_nxt.src_en[reg_req.addr[1:0]] = reg_req.wdata[0];
              GRP_DIV:    s_nxt.div[reg_req.addr[1:0]]    = reg_req.wdata;
              GRP_WRAP:   s_nxt.wrap[reg_req.addr[1:0]]   = reg_req.wdata;
              default:    s_nxt.feat_en = s_r.feat_en;
            endcase
          end
        end
      endcase
    end

    // Measurement sequence. A store placed after the clear wins when both meet.
    case (s_r.state)
      PWC_OFF:
      begin
        s_nxt.high_res = 32'h0;
        s_nxt.low_pend = 32'h0;
        s_nxt.hi_cnt   = 32'h0;
        s_nxt.lo_cnt   = 32'h0;
        if (active)
          s_nxt.state = PWC_ARM;
      end
      PWC_ARM:
      begin
        if (rise)
        begin
          s_nxt.hi_cnt = 32'h0;
          s_nxt.state  = PWC_HIGH;
        end
      end
      PWC_HIGH:
      begin
        if (fall)
        begin
          s_nxt.hi_meas = s_r.hi_cnt;
          s_nxt.lo_cnt  = 32'h0;
          s_nxt.state   = PWC_LOW;
        end
        else if (tick)
          s_nxt.hi_cnt = pwc_wrap_inc(s_r.hi_cnt, wrap);
      end
      PWC_LOW:
      begin
        // Gated by the enable, so a rise in the cycle of a disable leaves the result alone.
        if (store)
        begin
          s_nxt.high_res = s_r.hi_meas;
          s_nxt.low_pend = s_r.lo_cnt;
          s_nxt.hi_cnt   = 32'h0;
          s_nxt.state    = cont ? PWC_HIGH : PWC_HOLD;
        end
        else if (tick)
          s_nxt.lo_cnt = pwc_wrap_inc(s_r.lo_cnt, wrap);
      end
      PWC_HOLD:
      begin
        if (prim_rd || cont)
          s_nxt.state = PWC_ARM;
      end
      default: s_nxt.state = PWC_OFF;
    endcase

    if (!active)
      s_nxt.state = PWC_OFF;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign reg_rsp     = s_r.rsp;
  assign meas_active = (s_r.state != PWC_OFF);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  enable_off_a: assert property (!active |=> s_r.state == PWC_OFF)
    else $error("Measurement ran while disabled.");
  select_gate_a: assert property ((s_r.feat_sel != FEATURE_PULSE_WIDTH) |=> !meas_active)
    else $error("Measurement ran with another feature selected.");
  period_store_a: assert property (store |=> s_r.high_res == $past(s_r.hi_meas))
    else $error("High time not stored at closing rising edge.");
  cont_refresh_a: assert property ((store && cont) |=> s_r.state == PWC_HIGH)
    else $error("Continuous mode did not restart on rising edge.");
  oneshot_hold_a: assert property ((store && !cont) |=> s_r.state == PWC_HOLD ##1
                                   (s_r.state == PWC_HOLD || $past(prim_rd) || $past(cont)
                                    || !$past(active)))
    else $error("One-shot left hold without a primary read.");
  capture_read_a: assert property (!prim_rd |=> $stable(s_r.low_cap))
    else $error("Secondary result changed without a primary read.");
  capture_pair_a: assert property (prim_rd |=> s_r.low_cap == $past(s_r.low_pend))
    else $error("Secondary result does not match the read high time.");
  read_clear_a: assert property ((clr_rd && !store) |=> s_r.high_res == 32'h0)
    else $error("Read-and-clear left a nonzero result.");
  result_hold_a: assert property ((!store && !clr_rd && s_r.state != PWC_OFF)
                                  |=> $stable(s_r.high_res))
    else $error("Result changed without a rising edge.");
  zero_start_a: assert property (s_r.state == PWC_OFF |=> s_r.high_res == 32'h0)
    else $error("Result not zero before first period.");
  stream_low_a: assert property (
    (reg_req.rd && reg_req.stream && reg_req.addr == ADDR_HIGH_TICKS) |=>
    (reg_rsp.valid && reg_rsp.data == {{(32 - STREAM_W){1'b0}}, $past(s_r.high_res[STREAM_W-1:0])}
     && s_r.stream_hi == $past(s_r.high_res[31:STREAM_W])))
    else $error("Streaming read did not split the result.");
  count_wrap_a: assert property (
    (s_r.state == PWC_HIGH && !fall && tick && wrap != 32'h0 && s_r.hi_cnt == wrap - 32'h1)
    |=> s_r.hi_cnt == 32'h0)
    else $error("High counter did not wrap at the wrap value.");
  low_wrap_a: assert property (
    (s_r.state == PWC_LOW && !rise && tick && wrap != 32'h0 && s_r.lo_cnt == wrap - 32'h1)
    |=> s_r.lo_cnt == 32'h0)
    else $error("Low counter did not wrap at the wrap value.");
  read_answer_a: assert property (reg_rsp.valid == $past(reg_req.rd))
    else $error("Read answer not given exactly one cycle after the request.");
  off_clear_a: assert property (s_r.state == PWC_OFF |=> s_r.low_pend == 32'h0)
    else $error("Pending low time survived a disable.");
  high_stay_a: assert property ((s_r.state == PWC_HIGH && active && !fall) |=> s_r.state == PWC_HIGH)
    else $error("High phase ended without a falling edge.");

endmodule
`default_nettype wire

// [pwc_pulse_src.sv]
// Purpose: Pulse source standing on the far side of the measured line.
// Assumes: A burst is requested by holding go until busy rises.
// Notes:   Each burst ends with a short high and then idles low, so the last
//          closing rise is the one that sets the expected results.
`default_nettype none
module pwc_pulse_src
(
  // Clock
  input  wire logic        clk_sys,
  // Burst request
  input  wire logic        go,
  input  wire logic [31:0] high_len,
  input  wire logic [31:0] low_len,
  input  wire logic [31:0] count,
  // Line and status
  output logic             line_out,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ps;

  // The line changes only at falling edges, away from the sampling edge.
  task automatic level(input logic v, input logic [31:0] c);
    @(negedge clk_sys);
    line_out = v;
    repeat (c - 1) @(negedge clk_sys);
  endtask

  initial
  begin
    line_out = 1'b0;
    busy     = 1'b0;
    forever
    begin
      @(posedge clk_sys);
      if (go === 1'b1)
      begin
        busy = 1'b1;
        repeat (count)
        begin
          level(1'b1, high_len);
          level(1'b0, low_len);
        end
        level(1'b1, 32'h4);
        level(1'b0, 32'h3);
        @(posedge clk_sys);
        busy = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [pwc_top_tb.sv]
// Purpose: Self-checking bench of the pulse width capture block.
// Assumes: Divider one except in the divider sweep; the line comes from the pulse source.
// Notes:   Expected results come from an integer model updated by every write, read and burst.
`default_nettype none
module pwc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pwc_pkg::*;

  logic        clk_sys;
  logic        reset;
  logic        line_in;
  pwc_req_s    req;
  pwc_rsp_s    rsp;
  logic        meas_active;
  logic        go;
  logic        busy;
  logic [31:0] hl;
  logic [31:0] ll;
  logic [31:0] cnt;
  logic [31:0] seed;
  logic [31:0] cfg [4];
  longint      m_hi;
  longint      m_lo;
  longint      m_cap;
  longint      m_up;
  longint      m_wrap;
  bit          m_hold;
  int          error_cnt;
  int          checked;

  pwc_top i_pwc_top (.clk_sys(clk_sys), .reset(reset), .line_in(line_in), .reg_req(req),
                     .reg_rsp(rsp), .meas_active(meas_active));
  pwc_pulse_src i_pwc_pulse_src (.clk_sys(clk_sys), .go(go), .high_len(hl), .low_len(ll),
                                 .count(cnt), .line_out(line_in), .busy(busy));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic longint wrapped(input longint x);
    return (m_wrap == 0) ? x : x % m_wrap;
  endfunction

  // Q16.16 seconds at divide-by-one; the design may land one step low.
  function automatic longint sec(input longint t);
    return (t * 65536) / longint'(CORE_RATE_HZ);
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic bus(input logic [4:0] a, input logic r, input logic s, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(negedge clk_sys);
    req = '{rd: r, wr: !r, stream: s, addr: a, wdata: d};
    @(negedge clk_sys);
    req.rd = 1'b0;
    req.wr = 1'b0;
    q = 32'h0;
    k = 0;
    while (r && rsp.valid !== 1'b1 && k < 4)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (r)
      q = rsp.data;
    if (k == 4)
      chk(1'b0, "read gave no answer");
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b0, 1'b0, d, q);
    if (a < 5'h04)
      cfg[a[1:0]] = d;
    if (a == 5'h18)
      m_wrap = d;
    if (a == 5'h00 || (a == 5'h03 && d[1]))
      m_hold = 1'b0;
    if (!(cfg[0][0] && cfg[1] == 32'h5))
    begin
      m_hi = 0;
      m_lo = 0;
    end
  endtask

  task automatic mread(input logic [4:0] a, input logic s, input int tol);
    longint      e;
    logic [31:0] q;
    e = 0;
    if (a < 5'h04)
      e = cfg[a[1:0]];
    if (a == 5'h04 || a == 5'h08)
      e = m_hi;
    if (a == 5'h06 || a == 5'h09)
      e = sec(m_hi);
    if (a == 5'h05)
      e = m_cap;
    if (a == 5'h07)
      e = sec(m_cap);
    if (a == 5'h0A)
      e = m_up;
    if (a inside {5'h04, 5'h06, 5'h08, 5'h09})
    begin
      m_cap  = m_lo;
      m_hold = 1'b0;
    end
    if (a == 5'h08 || a == 5'h09)
    begin
      m_hi = 0;
      m_lo = 0;
    end
    if (s)
    begin
      m_up = e >> 16;
      e    = e & 64'hFFFF;
    end
    bus(a, 1'b1, s, 32'h0, q);
    checked++;
    if (((q <= e) && (q + tol >= e)) !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: index %h got %h expected %h", $time, a, q, e);
    end
  endtask

  task automatic pulse(input int h, input int l, input int n);
    int k;
    @(negedge clk_sys);
    go  = 1'b1;
    hl  = 32'(h);
    ll  = 32'(l);
    cnt = 32'(n);
    k   = 0;
    while (busy !== 1'b1 && k < 8)
    begin
      @(negedge clk_sys);
      k++;
    end
    go = 1'b0;
    while (busy !== 1'b0 && k < 80000)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 80000)
      chk(1'b0, "pulse burst hung");
    if (cfg[0][0] && cfg[1] == 32'h5 && !m_hold)
    begin
      m_hi   = wrapped(h - 1);
      m_lo   = wrapped(l - 1);
      m_hold = !cfg[3][1];
    end
  endtask

  initial
  begin
    repeat (95000) @(posedge clk_sys);
    chk(1'b0, "run too long");
    conclude();
  end

  initial
  begin
    logic [31:0] dtab [9];
    logic [31:0] dd;
    dtab = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h20, 32'h40, 32'h100, 32'h0};
    req = '0;
    go = 1'b0;
    hl = 32'h0;
    ll = 32'h0;
    cnt = 32'h0;
    reset = 1'b1;
    seed = 32'h7AA1;
    cfg = '{default: 32'h0};
    {m_hi, m_lo, m_cap, m_up, m_wrap, m_hold} = '0;
    error_cnt = 0;
    checked = 0;
    repeat (4) @(negedge clk_sys);
    reset = 1'b0;
    chk(meas_active === 1'b0 && rsp.valid === 1'b0, "busy after reset");
    for (int a = 0; a < 4; a++)
      mread(5'(a), 1'b0, 0);
    mread(5'h1F, 1'b0, 0);
    $display("test reset finished");
    for (int s = 0; s < 3; s++)
      wr(5'(5'h10 + s), 32'h1);
    wr(5'h01, 32'h5);
    wr(5'h03, 32'h2);
    wr(5'h00, 32'h1);
    @(negedge clk_sys);
    chk(meas_active === 1'b1, "not active after enable");
    mread(5'h04, 1'b0, 0);
    for (int i = 0; i < 4; i++)
    begin
      pulse(2 + rnd() % 30, 2 + rnd() % 30, 1 + rnd() % 3);
      mread(5'h04, 1'b0, 0);
      mread(5'h05, 1'b0, 0);
      mread(5'h04, 1'b0, 0);
      wr(5'h04, rnd());
      mread(5'h04, 1'b0, 0);
    end
    $display("test continuous finished");
    pulse(11, 8, 2);
    mread(5'h08, 1'b0, 0);
    mread(5'h05, 1'b0, 0);
    mread(5'h04, 1'b0, 0);
    wr(5'h00, 32'h0);
    wr(5'h18, 32'h5);
    wr(5'h00, 32'h1);
    pulse(13, 9, 2);
    mread(5'h04, 1'b0, 0);
    mread(5'h05, 1'b0, 0);
    wr(5'h00, 32'h0);
    wr(5'h18, 32'h0);
    wr(5'h03, 32'h0);
    wr(5'h00, 32'h1);
    $display("test wrap and clear finished");
    pulse(10, 7, 1);
    pulse(20, 15, 1);
    chk(meas_active === 1'b1, "inactive while holding");
    mread(5'h04, 1'b0, 0);
    mread(5'h05, 1'b0, 0);
    pulse(12, 5, 1);
    mread(5'h08, 1'b0, 0);
    mread(5'h04, 1'b0, 0);
    $display("test one shot finished");
    wr(5'h00, 32'h0);
    wr(5'h03, 32'h2);
    wr(5'h00, 32'h1);
    pulse(65540, 3, 1);
    mread(5'h04, 1'b1, 0);
    mread(5'h0A, 1'b0, 0);
    mread(5'h05, 1'b1, 0);
    mread(5'h0A, 1'b0, 0);
    mread(5'h06, 1'b0, 1);
    mread(5'h07, 1'b0, 1);
    mread(5'h09, 1'b0, 1);
    mread(5'h04, 1'b0, 0);
    $display("test stream and seconds finished");
    for (int k = 0; k < 9; k++)
    begin
      dd = (dtab[k] == 32'h0) ? 32'h1 : dtab[k];
      wr(5'h00, 32'h0);
      wr(5'(5'h14 + k % 3), dtab[k]);
      wr(5'h02, 32'(k % 3));
      wr(5'h00, 32'h1);
      pulse(6 * dd, 6 * dd, 1);
      m_hi = 6;
      m_lo = 6;
      mread(5'h04, 1'b0, 1);
      mread(5'h05, 1'b0, 1);
    end
    $display("test divider finished");
    wr(5'h00, 32'h0);
    @(negedge clk_sys);
    chk(meas_active === 1'b0, "active after disable");
    pulse(5, 5, 1);
    mread(5'h04, 1'b0, 0);
    wr(5'h01, 32'h3);
    wr(5'h00, 32'h1);
    pulse(5, 5, 1);
    mread(5'h04, 1'b0, 0);
    $display("test disable finished");
    conclude();
  end
endmodule
`default_nettype wire
